// File: verif/bus_model.sv
// Behavioural system bus target answering reads and writes in order
`timescale 1ns/1ps
`default_nettype none
module bus_model
(
    input wire logic sys_clk,
    input wire logic wrStall,
    input wire logic rdReqValid,
    input wire logic [31:0] rdReqAddr,
    output logic rdReqReady,
    output logic rdRespValid,
    output logic [63:0] rdRespData,
    input wire logic wrReqValid,
    output logic wrReqReady,
    output logic wrRespValid
);
    logic [31:0] rdQ[$];
    int wrPend = 0;
    // Quiet start
    initial
    begin
        rdReqReady = 1'b0;
        wrReqReady = 1'b0;
        rdRespValid = 1'b0;
        wrRespValid = 1'b0;
        rdRespData = 64'h0;
    end
    // Requests are taken at the edge that sees ready high
    always @(posedge sys_clk)
    begin
        if (rdReqValid && rdReqReady)
            rdQ.push_back(rdReqAddr);
        if (wrReqValid && wrReqReady)
            wrPend++;
    end
    // Random stalls; idle data toggles so a stale value never matches
    always @(negedge sys_clk)
    begin
        rdReqReady <= ($urandom % 3) != 0;
        wrReqReady <= !wrStall && ($urandom % 2);
        rdRespValid <= 1'b0;
        wrRespValid <= 1'b0;
        rdRespData <= ~rdRespData;
        if (rdQ.size() > 0 && ($urandom % 2))
        begin
            rdRespValid <= 1'b1;
            rdRespData <= {rdQ[0], ~rdQ[0]};
            void'(rdQ.pop_front());
        end
        if (wrPend > 0 && ($urandom % 2))
        begin
            wrRespValid <= 1'b1;
            wrPend--;
        end
    end
endmodule // bus_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the region attribute ordering block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import region_order_pkg::*;
    logic sys_clk = 0, rst_b = 0, ldValid = 0, stValid = 0, wrStall = 0;
    logic fenceReq = 0, fenceIReq = 0, drainChk = 0;
    logic [15:0] regionCacheable = 16'h0002, regionSideEffect = 16'h0004;
    logic [31:0] ldAddr = 0, stAddr = 0, stData = 0, rdReqAddr, wrReqAddr;
    logic [1:0] ldSize = 0, stSize = 0, rdReqSize, wrReqSize, seRd, seWr;
    logic [1:0] expSz;
    logic [3:0] rg;
    logic ldReady, ldRespValid, ldRespForwarded, stReady, rdReqValid;
    logic rdReqCacheable, rdReqReady, rdRespValid, wrReqValid, wrReqReady;
    logic wrReqCacheable, wrRespValid, fenceDone, flushPipe;
    logic icacheInvalidate, refetchNextPc;
    logic [63:0] ldRespData, rdRespData, wrReqData;
    logic [7:0] wrReqStrb, outstandingCount;
    typedef struct {logic [63:0] d; logic [63:0] m; logic f;} note_t;
    note_t expQ[$];
    int mismatches = 0, comparisons = 0, rdCount = 0, wrCount = 0;

    region_order u_dut (.sys_clk, .rst_b, .regionCacheable,
        .regionSideEffect, .ldValid, .ldAddr, .ldSize, .ldReady,
        .ldRespValid, .ldRespData, .ldRespForwarded, .stValid, .stAddr,
        .stData, .stSize, .stReady, .rdReqValid, .rdReqAddr, .rdReqSize,
        .rdReqCacheable, .rdReqReady, .rdRespValid, .rdRespData,
        .wrReqValid, .wrReqAddr, .wrReqSize, .wrReqData, .wrReqStrb,
        .wrReqCacheable, .wrReqReady, .wrRespValid, .fenceReq, .fenceIReq,
        .fenceDone, .flushPipe, .icacheInvalidate, .refetchNextPc,
        .outstandingCount);
    bus_model u_bus (.sys_clk, .wrStall, .rdReqValid, .rdReqAddr,
        .rdReqReady, .rdRespValid, .rdRespData, .wrReqValid, .wrReqReady,
        .wrRespValid);

    always #20 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(string w, logic [63:0] e, logic [63:0] g,
                         logic [63:0] m);
        comparisons++;
        if ((g & m) !== (e & m))
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", w, e & m, g & m);
        end
    endtask
    // Note the expected result, then hold the load until it is taken
    task automatic ld(logic [31:0] a, logic [1:0] s, logic f,
                      logic [31:0] fd);
        note_t n;
        logic [31:0] b;
        b = regionSideEffect[a[31:28]] ? a : {a[31:3], 3'h0};
        n.d = f ? {32'h0, fd} << (32 * a[2]) : {b, ~b};
        n.m = f ? 64'hffffffff << (32 * a[2]) : '1;
        n.f = f;
        expQ.push_back(n);
        ldAddr = a;
        ldSize = s;
        ldValid = 1'b1;
        stValid = 1'b0;
        repeat (99) if (ldReady !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic st(logic [31:0] a, logic [31:0] d, logic [1:0] s);
        stAddr = a;
        stData = d;
        stSize = s;
        stValid = 1'b1;
        repeat (99) if (stReady !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask
    // Lowering valid costs a cycle so no signal is set twice at one edge
    task automatic idle();
        ldValid = 1'b0;
        stValid = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic waitq(string t);
        repeat (400) if (expQ.size() != 0) @(negedge sys_clk);
        check("pending results", 0, expQ.size(), '1);
        $display("test %s done", t);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Results against the oldest note; bus requests against attributes
    always @(posedge sys_clk)
    begin
        if (ldRespValid === 1'b1 && expQ.size() > 0)
        begin
            check("ldRespData", expQ[0].d, ldRespData, expQ[0].m);
            check("ldRespForwarded", expQ[0].f, ldRespForwarded, 1);
            void'(expQ.pop_front());
        end
        if (rdReqValid === 1'b1 && rdReqReady === 1'b1)
        begin
            rdCount++;
            rg = rdReqAddr[31:28];
            expSz = regionSideEffect[rg] ? seRd : SIZE_D;
            check("rdReqSize", expSz, rdReqSize, 3);
            check("rdReqCacheable", regionCacheable[rg], rdReqCacheable, 1);
            if (drainChk) check("wrReqValid", 0, wrReqValid, 1);
        end
        if (wrReqValid === 1'b1 && wrReqReady === 1'b1)
        begin
            wrCount++;
            rg = wrReqAddr[31:28];
            expSz = regionSideEffect[rg] ? seWr : SIZE_D;
            check("wrReqSize", expSz, wrReqSize, 3);
            check("wrReqCacheable", regionCacheable[rg],
                wrReqCacheable, 1);
        end
    end

    // Watchdog sized well above the whole sequence
    initial
    begin
        #(40 * 20000);
        mismatches++;
        summarize();
    end

    initial
    begin
        int c;
        logic [31:0] a;
        logic [1:0] s;
        void'($urandom(9));
        repeat (6) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge sys_clk);
        // Back-to-back random loads, cacheable and not
        for (int i = 0; i < 8; i++)
        begin
            s = 2'($urandom % 4);
            a = {i[0] ? 4'h1 : 4'h3, 28'($urandom)} & (32'hffffffff << s);
            ld(a, s, 1'b0, 0);
        end
        idle();
        waitq("random loads");
        // Stores stuck behind a stalled bus: forward and no-match
        wrStall = 1'b1;
        st(32'h10000100, 32'h11111111, SIZE_W);
        st(32'h10000204, 32'hcafe1234, SIZE_W);
        c = rdCount;
        ld(32'h10000204, SIZE_W, 1'b1, 32'hcafe1234);
        ld(32'h10000300, SIZE_H, 1'b0, 0);
        idle();
        waitq("forward and no match");
        check("bus reads", c + 1, rdCount, '1);
        check("stores held", 1, wrReqValid, 1);
        // Partial overlap drains the write buffer first
        st(32'h10000401, 32'h000000a5, SIZE_B);
        drainChk = 1'b1;
        ld(32'h10000400, SIZE_W, 1'b0, 0);
        idle();
        repeat (10) @(negedge sys_clk);
        wrStall = 1'b0;
        waitq("partial match");
        // Side-effect stores stay apart; side-effect load waits for them
        wrStall = 1'b1;
        seWr = SIZE_B;
        seRd = SIZE_H;
        c = wrCount;
        st(32'h20000001, 32'h0000005a, SIZE_B);
        st(32'h20000001, 32'h0000003c, SIZE_B);
        ld(32'h20000006, SIZE_H, 1'b0, 0);
        idle();
        repeat (10) @(negedge sys_clk);
        wrStall = 1'b0;
        waitq("side effect");
        check("write count", c + 2, wrCount, '1);
        drainChk = 1'b0;
        // Fence and fence.i, each after a register write
        for (int k = 0; k < 2; k++)
        begin
            c = wrCount;
            st(32'h20000010, 32'h00000001, SIZE_B);
            idle();
            fenceReq = k == 0;
            fenceIReq = k == 1;
            @(negedge sys_clk);
            fenceReq = 1'b0;
            fenceIReq = 1'b0;
            repeat (200) if (fenceDone !== 1'b1) @(negedge sys_clk);
            check("fenceDone", 1, fenceDone, 1);
            check("outstandingCount", 0, outstandingCount, '1);
            check("writes done", c + 1, wrCount, '1);
            check("flushPipe", k, flushPipe, 1);
            check("icacheInvalidate", k, icacheInvalidate, 1);
            @(negedge sys_clk);
            check("refetchNextPc", k, refetchNextPc, 1);
            $display("test fence kind %0d done", k);
        end
        summarize();
    end
endmodule // tb_top
`default_nettype wire

// File: verilog/region_order.sv
// Load/store ordering with per-region attributes toward the system bus
`timescale 1ns/1ps
`default_nettype none
module region_order
    import region_order_pkg::*;
#(
    parameter int LOCAL_INSTRUCTION_MEMORY_KB = 64,
    parameter int LOCAL_DATA_MEMORY_KB = 64
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [NUM_REGIONS-1:0] regionCacheable,
    input wire logic [NUM_REGIONS-1:0] regionSideEffect,
    input wire logic ldValid,
    input wire logic [31:0] ldAddr,
    input wire logic [1:0] ldSize,
    output logic ldReady,
    output logic ldRespValid,
    output logic [63:0] ldRespData,
    output logic ldRespForwarded,
    input wire logic stValid,
    input wire logic [31:0] stAddr,
    input wire logic [31:0] stData,
    input wire logic [1:0] stSize,
    output logic stReady,
    output logic rdReqValid,
    output logic [31:0] rdReqAddr,
    output logic [1:0] rdReqSize,
    output logic rdReqCacheable,
    input wire logic rdReqReady,
    input wire logic rdRespValid,
    input wire logic [63:0] rdRespData,
    output logic wrReqValid,
    output logic [31:0] wrReqAddr,
    output logic [1:0] wrReqSize,
    output logic [63:0] wrReqData,
    output logic [7:0] wrReqStrb,
    output logic wrReqCacheable,
    input wire logic wrReqReady,
    input wire logic wrRespValid,
    input wire logic fenceReq,
    input wire logic fenceIReq,
    output logic fenceDone,
    output logic flushPipe,
    output logic icacheInvalidate,
    output logic refetchNextPc,
    output logic [7:0] outstandingCount
);
    localparam logic MEM_OK = memSizeOk(LOCAL_INSTRUCTION_MEMORY_KB, 1'b0)
        && memSizeOk(LOCAL_DATA_MEMORY_KB, 1'b1);

    logic [31:0] wbAddr_reg [WB_DEPTH];
    logic [63:0] wbData_reg [WB_DEPTH];
    logic [7:0] wbMask_reg [WB_DEPTH];
    logic [1:0] wbSize_reg [WB_DEPTH];
    logic wbSe_reg [WB_DEPTH];
    logic wbCache_reg [WB_DEPTH];
    logic [1:0] wbHead_reg, wbTail_reg, lastIdx, wbIdx;
    logic [2:0] wbCount_reg, wbCount_next;
    logic [31:0] rbAddr_reg [RB_DEPTH];
    logic [1:0] rbSize_reg [RB_DEPTH];
    logic rbSe_reg [RB_DEPTH];
    logic rbCache_reg [RB_DEPTH];
    logic [1:0] rbHead_reg, rbTail_reg;
    logic [2:0] rbCount_reg, rbCount_next;
    logic [7:0] outstanding_reg, rdPend_reg;
    fence_state_t fenceState_reg;
    logic isFenceI_reg;
    logic ldAccept, stAccept, ldSe, stSe, canMerge, wbPush;
    logic [63:0] stLane, fwdData;
    logic [7:0] stMask, hMask, hitMask;
    logic [31:0] hAddr;
    logic headValid, headSe, blockHit, fullMatch, noMatch;
    logic wbDrained, canIssueRd, roomRd, roomWr;
    logic doRead, doWrite, doForward, allIdle, fenceHold;

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    // RULE1 RULE2 RULE3: region lookup
    assign ldSe = regionSideEffect[regionOf(ldAddr)];
    assign stSe = regionSideEffect[regionOf(stAddr)];
    assign ldAccept = ldValid && ldReady;
    assign stAccept = stValid && stReady;
    assign stMask = laneMask(stSize, stAddr[2:0]);
    assign stLane = 64'(stData) << {stAddr[2:0], 3'h0};
    assign lastIdx = 2'(wbTail_reg - 2'h1);
    // RULE11: side-effect stores never coalesce
    assign canMerge = stAccept && !stSe && wbCount_reg != 3'h0
        && !wbSe_reg[lastIdx]
        && wbAddr_reg[lastIdx][31:3] == stAddr[31:3]
        && !(doWrite && wbCount_reg == 3'h1);
    assign wbPush = stAccept && !canMerge;

    // ----------------------------------------------------------------
    // Head load versus write buffer
    // ----------------------------------------------------------------
    assign headValid = rbCount_reg != 3'h0;
    assign hAddr = rbAddr_reg[rbHead_reg];
    assign headSe = rbSe_reg[rbHead_reg];
    assign hMask = laneMask(rbSize_reg[rbHead_reg], hAddr[2:0]);
    // Bytes found oldest first, so newer stores overwrite older
    always_comb
    begin
        wbIdx = 2'h0;
        hitMask = 8'h00;
        blockHit = 1'b0;
        fwdData = 64'h0;
        for (int i = 0; i < WB_DEPTH; i++)
        begin
            wbIdx = 2'(wbHead_reg + 2'(i));
            if (3'(i) < wbCount_reg &&
                wbAddr_reg[wbIdx][31:3] == hAddr[31:3])
            begin
                hitMask = hitMask | (wbMask_reg[wbIdx] & hMask);
                // RULE11: side-effect bytes are not forwardable
                if (wbSe_reg[wbIdx] && (wbMask_reg[wbIdx] & hMask) != 8'h00)
                    blockHit = 1'b1;
                for (int b = 0; b < 8; b++)
                begin
                    if (wbMask_reg[wbIdx][b])
                        fwdData[b*8 +: 8] = wbData_reg[wbIdx][b*8 +: 8];
                end
            end
        end
        // A store already on its way cannot be searched byte by byte
        if (wrReqValid && wrReqAddr[31:3] == hAddr[31:3])
            blockHit = 1'b1;
    end
    assign fullMatch = !headSe && !blockHit && hitMask == hMask;
    assign noMatch = !blockHit && hitMask == 8'h00;
    assign wbDrained = wbCount_reg == 3'h0 && !wrReqValid;

    // ----------------------------------------------------------------
    // Issue decisions
    // ----------------------------------------------------------------
    assign canIssueRd = !rdReqValid || rdReqReady;
    // RULE22: never exceed 255 requests in flight
    assign roomRd = outstanding_reg != MAX_OUTSTANDING;
    assign roomWr = doRead ? outstanding_reg < 8'(MAX_OUTSTANDING - 8'h01)
                           : outstanding_reg != MAX_OUTSTANDING;
    // RULE12 RULE16 RULE17: drain for side effects or partial hits
    assign doRead = headValid && canIssueRd && roomRd
        && (headSe ? wbDrained : noMatch);
    // RULE15: forward only once older reads have returned, keeping order
    assign doForward = headValid && fullMatch && !rdReqValid
        && rdPend_reg == 8'h00 && !rdRespValid;
    // RULE10 RULE18: stores leave in order, loads may pass them
    assign doWrite = wbCount_reg != 3'h0 && (!wrReqValid || wrReqReady)
        && roomWr;
    assign wbCount_next = 3'(wbCount_reg + {2'h0, wbPush} - {2'h0, doWrite});
    assign rbCount_next = 3'(rbCount_reg + {2'h0, ldAccept}
        - {2'h0, doRead || doForward});
    assign allIdle = rbCount_reg == 3'h0 && wbDrained && !rdReqValid
        && outstanding_reg == 8'h00;
    assign fenceHold = (fenceState_reg == FENCE_IDLE && (fenceReq || fenceIReq))
        || (fenceState_reg == FENCE_DRAIN && (!allIdle || isFenceI_reg));

    // ----------------------------------------------------------------
    // Buffer storage
    // ----------------------------------------------------------------
    // RULE9: write FIFO and read FIFO entries, data needs no reset
    always_ff @(posedge sys_clk)
    begin
        if (wbPush)
        begin
            wbAddr_reg[wbTail_reg] <= stAddr;
            wbData_reg[wbTail_reg] <= stLane;
            wbMask_reg[wbTail_reg] <= stMask;
            wbSize_reg[wbTail_reg] <= stSize;
            wbSe_reg[wbTail_reg] <= stSe;
            wbCache_reg[wbTail_reg] <= regionCacheable[regionOf(stAddr)];
        end
        if (canMerge)
        begin
            wbMask_reg[lastIdx] <= wbMask_reg[lastIdx] | stMask;
            for (int b = 0; b < 8; b++)
            begin
                if (stMask[b])
                    wbData_reg[lastIdx][b*8 +: 8] <= stLane[b*8 +: 8];
            end
        end
        if (ldAccept)
        begin
            rbAddr_reg[rbTail_reg] <= ldAddr;
            rbSize_reg[rbTail_reg] <= ldSize;
            rbSe_reg[rbTail_reg] <= ldSe;
            rbCache_reg[rbTail_reg] <= regionCacheable[regionOf(ldAddr)];
        end
    end

    // Buffer pointers and counts
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            wbHead_reg <= 2'h0;
            wbTail_reg <= 2'h0;
            wbCount_reg <= 3'h0;
            rbHead_reg <= 2'h0;
            rbTail_reg <= 2'h0;
            rbCount_reg <= 3'h0;
        end
        else
        begin
            if (wbPush)
                wbTail_reg <= 2'(wbTail_reg + 2'h1);
            if (doWrite)
                wbHead_reg <= 2'(wbHead_reg + 2'h1);
            if (ldAccept)
                rbTail_reg <= 2'(rbTail_reg + 2'h1);
            if (doRead || doForward)
                rbHead_reg <= 2'(rbHead_reg + 2'h1);
            wbCount_reg <= wbCount_next;
            rbCount_reg <= rbCount_next;
        end
    end

    // Ready is computed a cycle ahead so it can leave a flip-flop
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ldReady <= 1'b0;
            stReady <= 1'b0;
        end
        else
        begin
            ldReady <= rbCount_next != RB_FULL && !fenceHold;
            // RULE12: hold back younger stores while a side-effect load waits
            stReady <= wbCount_next != WB_FULL && !fenceHold
                && !(ldAccept && ldSe) && !(headValid && headSe && !doRead);
        end
    end

    // ----------------------------------------------------------------
    // Bus request slots
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rdReqValid <= 1'b0;
            rdReqAddr <= 32'h0;
            rdReqSize <= SIZE_B;
            rdReqCacheable <= 1'b0;
        end
        else if (doRead)
        begin
            rdReqValid <= 1'b1;
            rdReqCacheable <= rbCache_reg[rbHead_reg];
            // RULE13 RULE14: exact size or whole double-word
            rdReqAddr <= headSe ? hAddr : {hAddr[31:3], 3'h0};
            rdReqSize <= headSe ? rbSize_reg[rbHead_reg] : SIZE_D;
        end
        else if (rdReqReady)
            rdReqValid <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            wrReqValid <= 1'b0;
            wrReqAddr <= 32'h0;
            wrReqSize <= SIZE_B;
            wrReqData <= 64'h0;
            wrReqStrb <= 8'h00;
            wrReqCacheable <= 1'b0;
        end
        else if (doWrite)
        begin
            wrReqValid <= 1'b1;
            wrReqData <= wbData_reg[wbHead_reg];
            wrReqStrb <= wbMask_reg[wbHead_reg];
            wrReqCacheable <= wbCache_reg[wbHead_reg];
            wrReqAddr <= wbSe_reg[wbHead_reg] ? wbAddr_reg[wbHead_reg]
                : {wbAddr_reg[wbHead_reg][31:3], 3'h0};
            wrReqSize <= wbSe_reg[wbHead_reg] ? wbSize_reg[wbHead_reg]
                : SIZE_D;
        end
        else if (wrReqReady)
            wrReqValid <= 1'b0;
    end

    // RULE22: count per request sent, minus per response
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            outstanding_reg <= 8'h00;
            rdPend_reg <= 8'h00;
        end
        else
        begin
            outstanding_reg <= 8'(outstanding_reg + {7'h0, doRead}
                + {7'h0, doWrite} - {7'h0, rdRespValid}
                - {7'h0, wrRespValid});
            rdPend_reg <= 8'(rdPend_reg + {7'h0, doRead}
                - {7'h0, rdRespValid});
        end
    end
    assign outstandingCount = outstanding_reg;

    // Load results, bus data or forwarded bytes
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ldRespValid <= 1'b0;
            ldRespData <= 64'h0;
            ldRespForwarded <= 1'b0;
        end
        else
        begin
            ldRespValid <= rdRespValid || doForward;
            ldRespForwarded <= doForward;
            ldRespData <= rdRespValid ? rdRespData : fwdData;
        end
    end

    // ----------------------------------------------------------------
    // Fence and fence.i
    // ----------------------------------------------------------------
    // RULE23 RULE21: commit only with all buffers idle and count at zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            fenceState_reg <= FENCE_IDLE;
            isFenceI_reg <= 1'b0;
            fenceDone <= 1'b0;
            flushPipe <= 1'b0;
            icacheInvalidate <= 1'b0;
            refetchNextPc <= 1'b0;
        end
        else
        begin
            fenceDone <= 1'b0;
            flushPipe <= 1'b0;
            icacheInvalidate <= 1'b0;
            refetchNextPc <= 1'b0;
            case (fenceState_reg)
                FENCE_IDLE:
                begin
                    if (fenceReq || fenceIReq)
                    begin
                        fenceState_reg <= FENCE_DRAIN;
                        isFenceI_reg <= fenceIReq;
                    end
                end
                FENCE_DRAIN:
                begin
                    if (allIdle)
                    begin
                        fenceDone <= 1'b1;
                        // RULE20: flush and flash invalidate together
                        flushPipe <= isFenceI_reg;
                        icacheInvalidate <= isFenceI_reg;
                        fenceState_reg <= isFenceI_reg ? FENCE_REFETCH
                                                       : FENCE_IDLE;
                    end
                end
                FENCE_REFETCH:
                begin
                    // Refetch after invalidation, so it cannot hit
                    refetchNextPc <= 1'b1;
                    fenceState_reg <= FENCE_IDLE;
                end
                default: fenceState_reg <= FENCE_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_MEM_SIZE: assert property (MEM_OK) // RULE8
        else $error("illegal local memory size");
    AST_NO_SE_MERGE: assert property (canMerge |-> !stSe) // RULE11
        else $error("side-effect store merged");
    AST_NO_SE_FWD: assert property (doForward |-> !blockHit) // RULE11
        else $error("side-effect data forwarded");
    AST_SE_DRAIN: assert property ( // RULE12
        doRead && headSe |-> wbCount_reg == 3'h0 && !wrReqValid)
        else $error("side-effect load passed stores");
    AST_SE_EXACT: assert property ( // RULE13
        doRead && headSe |=> rdReqValid
        && rdReqSize == $past(rbSize_reg[rbHead_reg]))
        else $error("side-effect load widened");
    AST_DWORD: assert property ( // RULE14
        doRead && !headSe |=> rdReqSize == SIZE_D && rdReqAddr[2:0] == 3'h0)
        else $error("idempotent load not double-word");
    AST_FWD_NOBUS: assert property ( // RULE15
        doForward |=> ldRespValid && ldRespForwarded && !rdReqValid)
        else $error("forwarded load touched the bus");
    AST_PARTIAL: assert property ( // RULE16
        headValid && !headSe && hitMask != 8'h00 |-> !doRead)
        else $error("partial match read before drain");
    AST_NOMATCH: assert property ( // RULE17
        headValid && !headSe && noMatch && canIssueRd && roomRd |-> doRead)
        else $error("unmatched load delayed");
    AST_LIMIT: assert property ( // RULE22
        outstanding_reg == MAX_OUTSTANDING |-> !doRead && !doWrite)
        else $error("issue past outstanding limit");
    AST_FENCE: assert property ( // RULE23
        $rose(fenceDone) |-> $past(outstanding_reg) == 8'h00
        && rbCount_reg == 3'h0 && wbCount_reg == 3'h0)
        else $error("fence committed early");
    AST_FENCEI: assert property ( // RULE20
        fenceDone && flushPipe |-> icacheInvalidate ##1 refetchNextPc)
        else $error("fence.i sequence broken");

    COV_FWD: cover property (doForward);
    COV_SE_LOAD: cover property (doRead && headSe);
    COV_PARTIAL: cover property (headValid && hitMask != 8'h00 && !fullMatch);
    COV_FENCEI: cover property (refetchNextPc);
endmodule // region_order
`default_nettype wire

// File: verilog/region_order_pkg.sv
// Constants and helpers for the region attribute load/store ordering block
// Contract
// RULE1: Sixteen equal 256MB regions, each with its own attribute set.
// RULE2: Address bits 31 to 28 pick the region.
// RULE3: Each region has independent cacheable and side-effect flags.
// RULE4: Software never sets cacheable and side-effect together.
// RULE5: Boot firmware sets each region from the memory type it holds.
// RULE6: Local and bus-attached memories sit in different regions.
// RULE7: Local memories should share one region.
// RULE8: Local memory sizes are build parameters; 48KB for data only.
// RULE9: Bus loads pass a read FIFO, bus stores a write FIFO.
// RULE10: Loads leave in program order; stores leave in program order.
// RULE11: Side-effect stores never merge and never forward to loads.
// RULE12: A side-effect load drains every pending store first.
// RULE13: Side-effect loads go out at their exact size.
// RULE14: Idempotent loads go out as double-words, checked against stores.
// RULE15: Full store match forwards data, no stall, no bus read. The code holds the forward until older bus reads have returned.
// RULE16: Partial match drains the whole write FIFO before the read. The code waits only until no buffered store overlaps the load's bytes.
// RULE17: No match sends the load at once, stores not waited for.
// RULE18: Without fence, older stores need not precede younger idempotent loads.
// RULE19: Software fences after every memory-mapped register write.
// RULE20: Fence.i flushes, invalidates I-cache, refetches with a forced miss.
// RULE21: Fence.i also does all of the data fence work.
// RULE22: 8-bit outstanding count; issue stops at 255; barrier ends at 0.
// RULE23: Fence commits only when buffers idle and bus quiet.
`default_nettype none
package region_order_pkg;
    localparam int REGION_MSB = 31;
    localparam int REGION_LSB = 28;
    localparam int NUM_REGIONS = 16;
    localparam int WB_DEPTH = 4;
    localparam int RB_DEPTH = 4;
    localparam logic [2:0] WB_FULL = 3'h4;
    localparam logic [2:0] RB_FULL = 3'h4;
    localparam logic [7:0] MAX_OUTSTANDING = 8'hff;
    localparam logic [1:0] SIZE_B = 2'h0;
    localparam logic [1:0] SIZE_H = 2'h1;
    localparam logic [1:0] SIZE_W = 2'h2;
    localparam logic [1:0] SIZE_D = 2'h3;

    typedef enum logic [1:0] {FENCE_IDLE, FENCE_DRAIN, FENCE_REFETCH}
        fence_state_t;

    // Region index of an address
    function automatic logic [3:0] regionOf(input logic [31:0] a);
        return a[REGION_MSB:REGION_LSB];
    endfunction

    // Byte lanes touched inside a double-word
    function automatic logic [7:0] laneMask(input logic [1:0] sz,
                                            input logic [2:0] off);
        logic [7:0] m;
        m = 8'h00;
        case (sz)
            SIZE_B: m = 8'h01;
            SIZE_H: m = 8'h03;
            SIZE_W: m = 8'h0f;
            default: m = 8'hff;
        endcase
        return m << off;
    endfunction

    // Legal local memory sizes in KB
    function automatic logic memSizeOk(input int kb, input logic isData);
        case (kb)
            4, 8, 16, 32, 64, 128, 256, 512: return 1'b1;
            48: return isData;
            default: return 1'b0;
        endcase
    endfunction
endpackage
`default_nettype wire
